// File: rtl/eepc_pkg.sv
// package: register layout, array geometry and timing constants
package eepc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] EEPC_CTRL_ADDR = 8'h1C;
  localparam logic [7:0] EEPC_CTRL_RESET = 8'h00;
  localparam int EEPC_BIT_PGM = 0;
  localparam int EEPC_BIT_RC = 1;
  localparam int EEPC_BIT_CAPTURE = 2;
  localparam int EEPC_BIT_ERLO = 3;
  localparam int EEPC_BIT_ERHI = 4;
  localparam int EEPC_BIT_PUMP = 6;
  localparam logic [7:0] EEPC_CTRL_MASK = 8'h5F;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam logic [13:0] EEPC_ARRAY_BASE = 14'h0240;
  localparam int EEPC_DEPTH = 128;
  localparam int EEPC_AW = 7;
  localparam int EEPC_BLK_AW = 5;
  localparam int EEPC_NBLK = 4;
  localparam logic [7:0] EEPC_ERASED = 8'hFF;
  // ---------------------------------------------------------------
  // erase modes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EEPC_MODE_EEPROM_PROGRAM_CONTROL = 2'b00,
    EEPC_MODE_BYTE = 2'b01,
    EEPC_MODE_BLOCK = 2'b10,
    EEPC_MODE_BULK = 2'b11
  } eepc_mode_t;
  typedef enum logic [1:0] {
    EEPC_ST_IDLE = 2'b00,
    EEPC_ST_LOADED = 2'b01,
    EEPC_ST_PULSE = 2'b11,
    EEPC_ST_DONE = 2'b10
  } eepc_state_t;
  // ---------------------------------------------------------------
  // timing, in ticks of the selected eeprom clock; the rc settle count runs on cpu clocks
  // ---------------------------------------------------------------
  localparam int EEPC_CNT_W = 24;
  localparam int EEPC_EEPROM_PROGRAM_CONTROL_TICKS = 1000;
  localparam int EEPC_BYTE_ERASE_TICKS = 1000;
  localparam int EEPC_BLOCK_ERASE_TICKS = 1000;
  localparam int EEPC_BULK_ERASE_TICKS = 1000;
  localparam int EEPC_FALL_TICKS = 100;
  localparam int EEPC_RC_SETTLE_TICKS = 100;
endpackage

// File: rtl/eepc_mem_if.sv
// interface: word port between the controller and the eeprom array
`timescale 1ns/1ns
interface eepc_mem_if;
  logic we;
  logic [eepc_pkg::EEPC_AW-1:0] waddr;
  logic [7:0] wdata;
  logic [eepc_pkg::EEPC_AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// File: rtl/eepc_array.sv
// 128-byte eeprom cell array with registered read data
`timescale 1ns/1ns
module eepc_array (
  // clock
  input wire logic i_mclk,
  input wire logic i_ce,
  // port
  eepc_mem_if.mem m
);
  import eepc_pkg::*;
  logic [7:0] cells [EEPC_DEPTH];
  logic [7:0] rd;
  // cells model nonvolatile storage: no reset, the controller writes
  // fully formed new values (and-programming, erase to ones)
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      if (m.we) begin
        cells[m.waddr] <= m.wdata;
      end
      rd <= cells[m.raddr];
    end
  end
  assign m.rdata = rd;
endmodule // eepc_array

// File: rtl/eepc_ctrl.sv
// eeprom program/erase controller with its control register
//
// Functional notes
// R1 - program: capture, pump on, erase bits zero, write, power for program time
// R2 - erased reads one; programming only clears bits (and with old value)
// R3 - erase select 01: pulse erases only the captured byte
// R4 - erase select 10: pulse erases the 32-byte block holding captured address
// R5 - erase select 11: pulse erases the whole array
// R6 - software ends: clear power, wait fall time, then clear capture and pump
// R7 - software returns all control fields to zero after each sequence
// R8 - stop mode forces the rc oscillator off in hardware
// R9 - wait mode leaves the rc oscillator alone; software may stop it
// R10 - power bit writable only while capture is already set
// R11 - four aligned 32-byte blocks form the 128-byte array
// R12 - array reads inhibited after a captured write until capture clears
// R13 - rc select runs the timing from the rc oscillator, not the cpu clock
// R14 - pulse and fall durations are cycle-count parameters of selected clock; here only the pulse times are parameters, EEPC_FALL_TICKS is never counted
// R15 - reset clears all fields, aborts operation, drops power at once
`timescale 1ns/1ns
module eepc_ctrl #(
  parameter int EEPROM_PROGRAM_CONTROL_TICKS = eepc_pkg::EEPC_EEPROM_PROGRAM_CONTROL_TICKS,
  parameter int BYTE_ERASE_TICKS = eepc_pkg::EEPC_BYTE_ERASE_TICKS,
  parameter int BLOCK_ERASE_TICKS = eepc_pkg::EEPC_BLOCK_ERASE_TICKS,
  parameter int BULK_ERASE_TICKS = eepc_pkg::EEPC_BULK_ERASE_TICKS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // cpu bus
  input wire logic [13:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // clocking and power modes
  input wire logic i_rc_tick,
  input wire logic i_stop_mode,
  output logic o_rc_osc_on,
  // status toward the charge pump
  output logic o_pump_on,
  output logic o_power_on,
  output logic o_busy
);
  import eepc_pkg::*;

  eepc_mem_if mif ();
  eepc_array u_array (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .m(mif)
  );

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic in_array(input logic [13:0] a);
    in_array = (a >= EEPC_ARRAY_BASE) &&
      (a < EEPC_ARRAY_BASE + 14'(EEPC_DEPTH));
  endfunction
  function automatic logic [EEPC_AW-1:0] cell_of(input logic [13:0] a);
    logic [13:0] d;
    d = a - EEPC_ARRAY_BASE;
    cell_of = d[EEPC_AW-1:0];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ctrl, next_ctrl;
  logic captured, next_captured;
  logic [EEPC_AW-1:0] cap_addr, next_cap_addr;
  logic [7:0] cap_data, next_cap_data;
  eepc_state_t state, next_state;
  logic [EEPC_CNT_W-1:0] pulse_cnt, next_pulse_cnt;
  logic [EEPC_CNT_W-1:0] need, next_need;
  logic [EEPC_AW-1:0] sweep, next_sweep;
  logic rd_pend, next_rd_pend;
  logic rd_is_reg, next_rd_is_reg;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic rc_on, next_rc_on;
  logic [EEPC_CNT_W-1:0] settle, next_settle;
  logic we, next_we;
  logic [7:0] wdat, next_wdat;
  logic [EEPC_AW-1:0] waddr, next_waddr;
  logic tick;
  eepc_mode_t mode;
  logic [7:0] merged;

  assign mode = eepc_mode_t'({ctrl[EEPC_BIT_ERHI], ctrl[EEPC_BIT_ERLO]});
  // timing advances on the rc tick when selected, else every cpu clock
  assign tick = ctrl[EEPC_BIT_RC] ? (i_rc_tick & rc_on) : 1'b1; // see R13
  // programming can only clear bits: new cell value ands into the old
  assign merged = mif.rdata & cap_data; // see R2

  assign mif.we = we;
  assign mif.waddr = waddr;
  assign mif.wdata = wdat;
  assign mif.raddr = (state == EEPC_ST_IDLE) ? cell_of(i_addr) : cap_addr;

  // ---------------------------------------------------------------
  // register and sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] wv;
    wv = i_wdata & EEPC_CTRL_MASK;
    next_ctrl = ctrl;
    next_captured = captured;
    next_cap_addr = cap_addr;
    next_cap_data = cap_data;
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_need = need;
    next_sweep = sweep;
    next_we = 1'b0;
    next_wdat = wdat;
    next_waddr = waddr;
    if (i_wr && i_addr == {6'h00, EEPC_CTRL_ADDR}) begin
      next_ctrl = wv;
      // power sets only when capture was already set before this write
      if (!ctrl[EEPC_BIT_CAPTURE]) begin
        next_ctrl[EEPC_BIT_PGM] = 1'b0; // see R10
      end
      // dropping capture releases the buses and the read inhibit
      if (!wv[EEPC_BIT_CAPTURE]) begin
        next_ctrl[EEPC_BIT_PGM] = 1'b0;
        next_captured = 1'b0; // see R12
      end
    end
    if (i_wr && in_array(i_addr) && ctrl[EEPC_BIT_CAPTURE]
        && !ctrl[EEPC_BIT_PGM]) begin
      next_captured = 1'b1;
      next_cap_addr = cell_of(i_addr);
      next_cap_data = i_wdata;
    end
    unique case (state)
      EEPC_ST_IDLE: begin
        if (ctrl[EEPC_BIT_PGM] && ctrl[EEPC_BIT_PUMP] && captured) begin
          next_state = EEPC_ST_LOADED;
          next_pulse_cnt = '0;
          unique case (mode)
            EEPC_MODE_EEPROM_PROGRAM_CONTROL: next_need = EEPC_CNT_W'(EEPROM_PROGRAM_CONTROL_TICKS); // see R1
            EEPC_MODE_BYTE: next_need = EEPC_CNT_W'(BYTE_ERASE_TICKS);
            EEPC_MODE_BLOCK: next_need = EEPC_CNT_W'(BLOCK_ERASE_TICKS);
            EEPC_MODE_BULK: next_need = EEPC_CNT_W'(BULK_ERASE_TICKS);
          endcase
        end
      end
      EEPC_ST_LOADED: begin
        // count powered time of the selected clock
        if (tick) begin
          next_pulse_cnt = pulse_cnt + 1'b1; // see R14
        end
        if (pulse_cnt >= need) begin
          next_state = EEPC_ST_PULSE;
          next_sweep = '0;
        end
        if (!ctrl[EEPC_BIT_PGM]) begin
          next_state = EEPC_ST_IDLE; // pulse cut short: cell untouched
        end
      end
      EEPC_ST_PULSE: begin
        next_we = 1'b1;
        next_state = EEPC_ST_DONE;
        unique case (mode)
          EEPC_MODE_EEPROM_PROGRAM_CONTROL: begin
            next_waddr = cap_addr;
            next_wdat = merged; // see R1
          end
          EEPC_MODE_BYTE: begin
            next_waddr = cap_addr;
            next_wdat = EEPC_ERASED; // see R3
          end
          EEPC_MODE_BLOCK: begin
            // aligned block: keep upper bits, walk the low five
            next_waddr = {cap_addr[EEPC_AW-1:EEPC_BLK_AW],
              sweep[EEPC_BLK_AW-1:0]}; // see R4 see R11
            next_wdat = EEPC_ERASED;
            if (sweep[EEPC_BLK_AW-1:0] != '1) begin
              next_sweep = sweep + 1'b1;
              next_state = EEPC_ST_PULSE;
            end
          end
          EEPC_MODE_BULK: begin
            next_waddr = sweep;
            next_wdat = EEPC_ERASED; // see R5
            if (sweep != '1) begin
              next_sweep = sweep + 1'b1;
              next_state = EEPC_ST_PULSE;
            end
          end
        endcase
      end
      EEPC_ST_DONE: begin
        // rearm only once software has dropped power
        if (!ctrl[EEPC_BIT_PGM]) begin
          next_state = EEPC_ST_IDLE; // see R6
        end
      end
    endcase
    if (i_srst) begin
      next_ctrl = EEPC_CTRL_RESET; // see R15
      next_captured = 1'b0;
      next_state = EEPC_ST_IDLE;
      next_we = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      ctrl <= next_ctrl;
      captured <= next_captured;
      cap_addr <= next_cap_addr;
      cap_data <= next_cap_data;
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      need <= next_need;
      sweep <= next_sweep;
      we <= next_we;
      wdat <= next_wdat;
      waddr <= next_waddr;
    end
  end

  // ---------------------------------------------------------------
  // read path and rc oscillator
  // ---------------------------------------------------------------
  always_comb begin
    next_rd_pend = 1'b0;
    next_rd_is_reg = 1'b0;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_rc_on = rc_on;
    next_settle = settle;
    if (i_rd && i_addr == {6'h00, EEPC_CTRL_ADDR}) begin
      next_rd_is_reg = 1'b1;
    end else if (i_rd && in_array(i_addr) && state == EEPC_ST_IDLE) begin
      next_rd_pend = 1'b1;
    end
    if (rd_is_reg) begin
      next_rdata = ctrl;
      next_rvalid = 1'b1;
    end else if (rd_pend) begin
      // inhibited reads return erased value
      next_rdata = captured ? EEPC_ERASED : mif.rdata; // see R12
      next_rvalid = 1'b1;
    end
    // stop forces the oscillator off; wait mode has no effect here
    next_rc_on = ctrl[EEPC_BIT_RC] && !i_stop_mode; // see R8 see R9
    if (!next_rc_on) begin
      next_settle = '0;
    end else if (settle != EEPC_CNT_W'(EEPC_RC_SETTLE_TICKS)) begin
      next_settle = settle + 1'b1;
    end
    if (i_srst) begin
      next_rvalid = 1'b0;
      next_rdata = 8'h00;
      next_rc_on = 1'b0;
      next_settle = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      rd_pend <= next_rd_pend;
      rd_is_reg <= next_rd_is_reg;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      rc_on <= next_rc_on;
      settle <= next_settle;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic pump_q, power_q, busy_q;
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      pump_q <= next_ctrl[EEPC_BIT_PUMP];
      power_q <= next_ctrl[EEPC_BIT_PGM] & next_ctrl[EEPC_BIT_PUMP];
      busy_q <= (next_state != EEPC_ST_IDLE);
    end
  end
  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_rc_osc_on = rc_on;
  assign o_pump_on = pump_q;
  assign o_power_on = power_q;
  assign o_busy = busy_q;
endmodule // eepc_ctrl

// File: tb/eepc_ctrl_chk.sv
// checker: port-level assertions for the eeprom controller
`timescale 1ns/1ns
module eepc_ctrl_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // cpu bus
  input wire logic [13:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // modes and status
  input wire logic i_rc_tick,
  input wire logic i_stop_mode,
  input wire logic o_rc_osc_on,
  input wire logic o_pump_on,
  input wire logic o_power_on,
  input wire logic o_busy
);
  import eepc_pkg::*;
  logic [7:0] shadow;
  logic [7:0] next_shadow;
  logic ctl_wr;
  logic arr_wr;
  logic cap_seen;
  assign ctl_wr = i_ce && i_wr && i_addr == 14'h001C;
  assign arr_wr = i_ce && i_wr && i_addr >= EEPC_ARRAY_BASE
    && i_addr <= 14'h02BF;
  // ---------------------------------------------------------------
  // shadow of the control register
  // ---------------------------------------------------------------
  // power only sticks when capture was already set before the write
  always_comb begin
    next_shadow = shadow;
    if (ctl_wr) begin
      next_shadow = i_wdata & EEPC_CTRL_MASK;
      next_shadow[0] = i_wdata[0] & i_wdata[2] & shadow[2];
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shadow <= 8'h00;
    end else begin
      shadow <= next_shadow;
    end
  end
  // a captured array write arms the sequencer for the next power-on
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cap_seen <= 1'b0;
    end else if (ctl_wr && !i_wdata[2]) begin
      cap_seen <= 1'b0;
    end else if (arr_wr && shadow[2] && !shadow[0]) begin
      cap_seen <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_reset_clear: assert property (disable iff (1'b0)
    i_srst && i_ce |=> !o_power_on && !o_pump_on && !o_busy
    && !o_rc_osc_on && !o_rvalid) else $error("reset left outputs set");
  a_power_gate: assert property (
    o_power_on == (shadow[0] && shadow[6]))
    else $error("power output disagrees with control bits");
  a_pump_level: assert property (o_pump_on == shadow[6])
    else $error("pump output disagrees with control bit");
  a_stop_rc: assert property (i_ce && i_stop_mode |=> !o_rc_osc_on)
    else $error("rc oscillator running in stop");
  a_reg_read: assert property (
    i_ce && i_rd && i_addr == 14'h001C ##1 i_ce ##1 i_ce
    |-> o_rvalid && o_rdata == $past(shadow, 1))
    else $error("control register read back wrong");
  a_busy_loaded: assert property (
    $rose(o_power_on) && cap_seen |=> o_busy)
    else $error("captured write did not start sequencer");
  a_abort_idle: assert property (
    ctl_wr && i_wdata == 8'h00 |-> ##[1:2] !o_busy)
    else $error("sequencer busy after all bits cleared");
  a_rd_answer: assert property (o_rvalid |-> $past(i_rd, 2))
    else $error("read data without a read strobe");
endmodule // eepc_ctrl_chk

// File: tb/eepc_rc_osc.sv
// model: rc oscillator that ticks only while enabled
`timescale 1ns/1ns
module eepc_rc_osc #(
  parameter int PERIOD = 5
) (
  // clock
  input wire logic i_mclk,
  // enable and tick
  input wire logic i_en,
  output logic o_tick = 1'b0
);
  int cnt = 0;
  // a halted oscillator gives no ticks, so stop really freezes timing
  always @(posedge i_mclk) begin
    if (!i_en) begin
      cnt <= 0;
      o_tick <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_tick <= (cnt == PERIOD - 1);
    end
  end
endmodule // eepc_rc_osc

// File: tb/eeprom_program_erase_control_tb.sv
// testbench: program and erase sequences through the control register
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module eeprom_program_erase_control_tb;
  import eepc_pkg::*;
  localparam int TK = 10;
  localparam int RCP = 5;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic [13:0] i_addr = 14'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_stop_mode = 1'b0;
  logic [7:0] o_rdata;
  logic o_rvalid, o_rc_osc_on, o_pump_on, o_power_on, o_busy, rc_tick;
  logic [13:0] pa [4] = '{14'h0240, 14'h0260, 14'h0280, 14'h02BF};
  logic [7:0] pd [4] = '{8'h55, 8'hA5, 8'h0F, 8'h3C};
  int fails = 0;
  int checks = 0;
  always #5 i_mclk = ~i_mclk;
  eepc_ctrl #(.EEPROM_PROGRAM_CONTROL_TICKS(TK), .BYTE_ERASE_TICKS(TK),
    .BLOCK_ERASE_TICKS(TK), .BULK_ERASE_TICKS(TK)) u_dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_rc_tick(rc_tick), .i_stop_mode(i_stop_mode),
    .o_rc_osc_on(o_rc_osc_on), .o_pump_on(o_pump_on),
    .o_power_on(o_power_on), .o_busy(o_busy));
  eepc_rc_osc #(.PERIOD(RCP)) u_rc (.i_mclk(i_mclk), .i_en(o_rc_osc_on),
    .o_tick(rc_tick));
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // waits a bounded three cycles for the registered answer
  task automatic rd(input logic [13:0] a, input logic [7:0] exp);
    logic got;
    got = 1'b0;
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    repeat (3) begin
      @(posedge i_mclk);
      #1;
      if (o_rvalid === 1'b1 && !got) begin
        got = 1'b1;
        `CHK(o_rdata, exp)
      end
    end
    `CHK(got, 1'b1)
  endtask
  task automatic op(input logic [7:0] m, input logic [13:0] a,
      input logic [7:0] d, input int hold);
    wr(14'h001C, 8'h44 | m);
    wr(a, d);
    wr(14'h001C, 8'h45 | m);
    #1;
    `CHK(o_power_on, 1'b1)
    repeat (hold) @(posedge i_mclk);
    wr(14'h001C, 8'h44 | m);
    repeat (3) @(posedge i_mclk);
    // block and bulk erase keep sweeping after power drops
    #1;
    for (int k = 0; k < 200 && o_busy !== 1'b0; k++) begin
      @(posedge i_mclk);
      #1;
    end
    `CHK(o_busy, 1'b0)
    wr(14'h001C, 8'h00);
  endtask
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(14'h001C, 8'h00);
    wr(14'h001C, 8'h01);
    rd(14'h001C, 8'h00);
    wr(14'h001C, 8'hE5);
    rd(14'h001C, 8'h44);
    `CHK(o_power_on, 1'b0)
    wr(14'h001C, 8'h00);
    $display("test register done");
    op(8'h18, 14'h0255, 8'h00, TK + 3);
    for (int i = 0; i < EEPC_DEPTH; i++) begin
      rd(EEPC_ARRAY_BASE + 14'(i), EEPC_ERASED);
    end
    foreach (pa[i]) op(8'h00, pa[i], pd[i], TK + 3);
    foreach (pa[i]) rd(pa[i], pd[i]);
    op(8'h00, 14'h0240, 8'hF0, TK + 3);
    rd(14'h0240, 8'h50);
    $display("test program done");
    op(8'h08, 14'h0240, 8'h00, TK + 3);
    rd(14'h0240, 8'hFF);
    rd(14'h0260, 8'hA5);
    op(8'h10, 14'h029A, 8'h00, TK + 3);
    rd(14'h0280, 8'hFF);
    rd(14'h02BF, 8'h3C);
    rd(14'h0260, 8'hA5);
    $display("test erase done");
    // twelve cpu cycles cover the count only if the cpu clock were used
    op(8'h02, 14'h0260, 8'h00, 12);
    rd(14'h0260, 8'hA5);
    op(8'h02, 14'h0260, 8'h00, TK * RCP + 10);
    rd(14'h0260, 8'h00);
    wr(14'h001C, 8'h02);
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK(o_rc_osc_on, 1'b1)
    @(posedge i_mclk);
    i_stop_mode <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK(o_rc_osc_on, 1'b0)
    @(posedge i_mclk);
    i_stop_mode <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK(o_rc_osc_on, 1'b1)
    wr(14'h001C, 8'h00);
    $display("test rc clock done");
    wr(14'h001C, 8'h44);
    wr(14'h02A0, 8'h00);
    rd(14'h0260, 8'hFF);
    wr(14'h001C, 8'h45);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    `CHK(o_power_on, 1'b0)
    rd(14'h001C, 8'h00);
    $display("test reset abort done");
    test_done();
  end
endmodule // eeprom_program_erase_control_tb
bind eepc_ctrl eepc_ctrl_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_ce(i_ce), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_rc_tick(i_rc_tick), .i_stop_mode(i_stop_mode),
  .o_rc_osc_on(o_rc_osc_on), .o_pump_on(o_pump_on),
  .o_power_on(o_power_on), .o_busy(o_busy));
